// [src/indirect_pointer_addressing.sv]
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Function
// - plain access uses pointer, pointer unchanged
// - post-increment: access, then pointer plus one
// - post-decrement: access, then pointer minus one
// - pre-increment: pointer plus one, then access
// - offset access: pointer plus working register
// - three pointers, five access slots each
// - access slots redirect to data memory
// - reset clears the 4-bit pointer high parts, not the pointer low bytes or the working register
module indirect_pointer_addressing (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [indirect_pointer_pkg::BUS_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [indirect_pointer_pkg::BUS_W-1:0] hwdata,
  input wire logic hready,
  output logic [indirect_pointer_pkg::BUS_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // data memory, combinational read
  output logic [indirect_pointer_pkg::PTR_W-1:0] memAddr,
  output logic [indirect_pointer_pkg::BYTE_W-1:0] memWrData,
  output logic memWrite,
  output logic memRead,
  input wire logic [indirect_pointer_pkg::BYTE_W-1:0] memRdData
);
  import indirect_pointer_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [HIGH_W-1:0] ptrHigh [NUM_PTR];
  logic [BYTE_W-1:0] ptrLow [NUM_PTR];
  logic [PTR_W-1:0] ptrFull [PTR_SLOTS];
  logic [BYTE_W-1:0] working;
  logic pendValid;
  logic pendWrite;
  logic [IDX_W-1:0] pendIdx;

  logic accept;
  logic [IDX_W-1:0] busIdx;
  logic readOp;
  logic writeOp;
  logic opFire;
  logic regWrite;
  logic [IDX_W-1:0] opIdx;
  logic [SEL_W-1:0] opSel;
  logic [SLOT_W-1:0] opSlot;
  logic [PTR_W-1:0] curPtr;
  logic [PTR_W-1:0] offsetExt;
  logic [PTR_W-1:0] effAddr;
  logic [PTR_W-1:0] nextPtr;
  logic [BYTE_W-1:0] regRead;

  // slot that redirects to memory rather than holding a value
  function automatic logic isVirtual(input logic [IDX_W-1:0] idx);
    return (idx[IDX_W-1 -: SEL_W] < SEL_W'(NUM_PTR)) && (idx[SLOT_W-1:0] <= SLOT_OFFSET);
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign accept = ce & hsel & hready & htrans[1];
  assign busIdx = (haddr[BUS_W-1:IDX_LSB+IDX_W] == '0) ? haddr[IDX_LSB +: IDX_W]
                                                       : IDX_UNMAPPED;
  assign readOp = accept & ~hwrite & isVirtual(busIdx);
  assign writeOp = ce & pendValid & pendWrite & isVirtual(pendIdx);
  assign opFire = readOp | writeOp;
  assign regWrite = ce & pendValid & pendWrite & ~isVirtual(pendIdx);
  assign opIdx = writeOp ? pendIdx : busIdx;
  assign opSel = opIdx[IDX_W-1 -: SEL_W];
  assign opSlot = opIdx[SLOT_W-1:0];
  assign curPtr = ptrFull[opSel];
  // stall while frozen so an address phase is never lost
  assign hreadyout = ce & ~pendValid;
  assign hresp = HRESP_OKAY;

  // ------------------------------------------------------------
  // address arithmetic
  // ------------------------------------------------------------
  always_comb begin
    offsetExt = {{(PTR_W-BYTE_W){working[BYTE_W-1]}}, working};
    effAddr = curPtr;
    nextPtr = curPtr;
    unique case (opSlot)
      SLOT_POSTINC: nextPtr = curPtr + 1'b1;
      SLOT_POSTDEC: nextPtr = curPtr - 1'b1;
      SLOT_PREINC: begin
        nextPtr = curPtr + 1'b1;
        effAddr = nextPtr;
      end
      SLOT_OFFSET: effAddr = curPtr + offsetExt;
      default: effAddr = curPtr;
    endcase
  end

  // ------------------------------------------------------------
  // pointers
  // ------------------------------------------------------------
  generate
    for (genvar p = 0; p < NUM_PTR; p++) begin : gPtr
      localparam logic [SEL_W-1:0] SEL = SEL_W'(p);

      assign ptrFull[p] = {ptrHigh[p], ptrLow[p]};

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ptrHigh[p] <= HIGH_RESET;
        end else if (opFire && opSel == SEL) begin
          ptrHigh[p] <= nextPtr[PTR_W-1 -: HIGH_W];
        end else if (regWrite && pendIdx == {SEL, SLOT_HIGH}) begin
          ptrHigh[p] <= hwdata[HIGH_W-1:0];
        end
      end

      // low byte keeps its value through reset
      always_ff @(posedge clk) begin
        if (rst_n && opFire && opSel == SEL) begin
          ptrLow[p] <= nextPtr[BYTE_W-1:0];
        end else if (rst_n && regWrite && pendIdx == {SEL, SLOT_LOW}) begin
          ptrLow[p] <= hwdata[BYTE_W-1:0];
        end
      end
    end
    for (genvar q = NUM_PTR; q < PTR_SLOTS; q++) begin : gPad
      assign ptrFull[q] = '0;
    end
  endgenerate

  // ------------------------------------------------------------
  // working register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_n && regWrite && pendIdx == IDX_WORKING) begin
      working <= hwdata[BYTE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // transfer tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pendValid <= 1'b0;
      pendWrite <= 1'b0;
      pendIdx <= IDX_UNMAPPED;
    end else if (ce) begin
      pendValid <= accept;
      if (accept) begin
        pendWrite <= hwrite;
        pendIdx <= busIdx;
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    regRead = '0;
    if (pendIdx == IDX_WORKING) begin
      regRead = working;
    end else if (pendIdx[SLOT_W-1:0] == SLOT_HIGH) begin
      regRead = BYTE_W'(ptrFull[pendIdx[IDX_W-1 -: SEL_W]][PTR_W-1 -: HIGH_W]);
    end else if (pendIdx[SLOT_W-1:0] == SLOT_LOW) begin
      regRead = ptrFull[pendIdx[IDX_W-1 -: SEL_W]][BYTE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (ce && pendValid && !pendWrite) begin
      hrdata <= BUS_W'(isVirtual(pendIdx) ? memRdData : regRead);
    end
  end

  // ------------------------------------------------------------
  // memory port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memAddr <= '0;
      memWrData <= '0;
      memWrite <= 1'b0;
      memRead <= 1'b0;
    end else if (ce) begin
      memRead <= readOp;
      memWrite <= writeOp;
      if (opFire) begin
        memAddr <= effAddr;
      end
      if (writeOp) begin
        memWrData <= hwdata[BYTE_W-1:0];
      end
    end
  end

endmodule

// [shared/indirect_pointer_pkg.sv]
package indirect_pointer_pkg;

  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int NUM_PTR = 3;
  localparam int PTR_SLOTS = 4;
  localparam int PTR_W = 12;
  localparam int HIGH_W = 4;
  localparam int BYTE_W = 8;
  localparam int BUS_W = 32;
  localparam int IDX_W = 5;
  localparam int IDX_LSB = 2;
  localparam int SEL_W = 2;
  localparam int SLOT_W = 3;

  // ------------------------------------------------------------
  // register index: pointer number in the upper bits, slot below
  // byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_PLAIN = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_POSTINC = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_POSTDEC = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_PREINC = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_OFFSET = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_HIGH = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_LOW = 3'h6;
  localparam logic [IDX_W-1:0] IDX_WORKING = 5'h18;
  localparam logic [IDX_W-1:0] IDX_UNMAPPED = 5'h1f;

  // ------------------------------------------------------------
  // reset values and bus codes
  // ------------------------------------------------------------
  localparam logic [HIGH_W-1:0] HIGH_RESET = 4'h0;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// [sim/data_memory_model.sv]
`timescale 1ns/10ps
module data_memory_model (
  // clock
  input wire logic clk,
  // memory port
  input wire logic [indirect_pointer_pkg::PTR_W-1:0] memAddr,
  input wire logic [indirect_pointer_pkg::BYTE_W-1:0] memWrData,
  input wire logic memWrite,
  input wire logic memRead,
  output logic [indirect_pointer_pkg::BYTE_W-1:0] memRdData
);
  import indirect_pointer_pkg::*;
  logic [BYTE_W-1:0] mem [1<<PTR_W];
  always_ff @(posedge clk) begin
    if (memWrite) begin
      mem[memAddr] <= memWrData;
    end
  end
  // read port floats to the inverse when not read
  assign memRdData = memRead ? mem[memAddr] : ~mem[memAddr];
endmodule

// [sim/indirect_pointer_props.sv]
`timescale 1ns/10ps
module indirect_pointer_props (
  // clock, reset, bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // memory port
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic [7:0] memRdData
);
  logic take;
  assign take = ce && hsel && hready && htrans[1];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state wrong");
  chk_read_cause: assert property (memRead |-> $past(take && !hwrite))
    else $error("memory read without bus read");
  chk_write_cause: assert property (memWrite |-> $past(take && hwrite, 2))
    else $error("memory write without bus write");
  chk_read_pulse: assert property (memRead |=> !memRead)
    else $error("read pulse too long");
  chk_write_pulse: assert property (memWrite |=> !memWrite)
    else $error("write pulse too long");
  chk_rdata_mem: assert property (memRead |=> hrdata == {24'h0, $past(memRdData)})
    else $error("read data not from memory");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_ops_apart: assert property (!(memRead && memWrite))
    else $error("read and write together");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
endmodule
bind indirect_pointer_addressing indirect_pointer_props props_u (.clk, .rst_n, .ce, .hsel,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .memWrite, .memRead, .memRdData);

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import indirect_pointer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, memWrite, memRead;
  logic [31:0] hrdata;
  logic [PTR_W-1:0] memAddr;
  logic [7:0] memWrData, memRdData;
  logic [7:0] shadow [1<<PTR_W];
  logic [PTR_W-1:0] e [NUM_PTR];
  int error_cnt = 0;
  int checked = 0;
  localparam logic [7:0] WK = 8'hfd;
  localparam logic [2:0] STEP [13] = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h3, 3'h2, 3'h4, 3'h4, 3'h2,
    3'h0, 3'h0, 3'h3, 3'h2};
  localparam logic [12:0] WRS = 13'h0a47;
  assign hready = hreadyout;
  always #50 clk = ~clk;
  indirect_pointer_addressing dut_u (.clk, .rst_n, .ce(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp(),
    .memAddr, .memWrData, .memWrite, .memRead, .memRdData);
  data_memory_model mem_u (.clk, .memAddr, .memWrData, .memWrite, .memRead, .memRdData);
  function automatic logic [31:0] ra(input int p, input logic [2:0] s);
    return {25'h0, 2'(p), s, 2'b00};
  endfunction
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
    r = hrdata;
    if (n >= 40) begin
      error_cnt++;
      wrap_up;
    end
  endtask
  task automatic ptrchk(input int p);
    logic [31:0] r;
    xfer(1'b0, ra(p, SLOT_LOW), 32'h0, r);
    chk(r, {24'h0, e[p][7:0]});
    xfer(1'b0, ra(p, SLOT_HIGH), 32'h0, r);
    chk(r, {28'h0, e[p][11:8]});
  endtask
  task automatic acc(input int p, input logic [2:0] s, input logic w, input logic [7:0] d);
    logic [PTR_W-1:0] ea;
    logic [31:0] r;
    ea = e[p];
    case (s)
      SLOT_POSTINC: e[p] = e[p] + 12'h1;
      SLOT_POSTDEC: e[p] = e[p] - 12'h1;
      SLOT_PREINC: begin
        e[p] = e[p] + 12'h1;
        ea = e[p];
      end
      SLOT_OFFSET: ea = e[p] + {{4{WK[7]}}, WK};
      default: ;
    endcase
    xfer(w, ra(p, s), {24'h0, d}, r);
    if (w) shadow[ea] = d;
    else chk(r, {24'h0, shadow[ea]});
    ptrchk(p);
  endtask
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < NUM_PTR; p++) begin
      xfer(1'b0, ra(p, SLOT_HIGH), 32'h0, r);
      chk(r, 32'h0);
    end
    xfer(1'b1, {25'h0, IDX_WORKING, 2'b00}, {24'h0, WK}, r);
    xfer(1'b0, {25'h0, IDX_WORKING, 2'b00}, 32'h0, r);
    chk(r, {24'h0, WK});
    xfer(1'b1, {25'h0, IDX_UNMAPPED, 2'b00}, 32'hff, r);
    xfer(1'b0, {25'h0, IDX_UNMAPPED, 2'b00}, 32'h0, r);
    chk(r, 32'h0);
    for (int p = 0; p < NUM_PTR; p++) begin
      xfer(1'b1, ra(p, SLOT_HIGH), {24'h0, 4'hf, 4'(p + 1)}, r);
      xfer(1'b1, ra(p, SLOT_LOW), 32'hff, r);
      e[p] = {4'(p + 1), 8'hff};
    end
    for (int p = 0; p < NUM_PTR; p++) begin
      for (int i = 0; i < 13; i++) begin
        acc(p, STEP[i], WRS[i], 8'(16 * p + i + 49));
      end
    end
    for (int p = 0; p < NUM_PTR; p++) begin
      ptrchk(p);
    end
    wrap_up;
  end
endmodule
